// ### hdl/strobe_decode_pkg.sv
package strobe_decode_pkg;
  localparam int          ADDR_W        = 20;
  localparam int          PAGE_W        = 8;
  localparam int          APB_ADDR_W    = 8;
  // Register offsets, byte addresses
  localparam logic [7:0]  CTRL_OFFSET   = 8'h00;
  localparam logic [7:0]  WIN0_OFFSET   = 8'h04;
  localparam logic [7:0]  WIN1_OFFSET   = 8'h08;
  localparam logic [7:0]  STATUS_OFFSET = 8'h0c;
  // Control fields
  localparam int          SHADOW_BIT    = 0;
  localparam int          INH_RD_BIT    = 1;
  localparam int          INH_WR_BIT    = 2;
  localparam int          ROM_OE_BIT    = 3;
  localparam int          RAM_LIMIT_LSB = 8;
  localparam logic [31:0] CTRL_RESET    = 32'h0000_a000;
  // Window fields
  localparam int          WIN_EN_BIT    = 0;
  localparam int          WIN_SEL_BIT   = 1;
  localparam int          WIN_BASE_LSB  = 4;
  localparam int          WIN_MASK_LSB  = 12;
  localparam logic [31:0] WIN_RESET     = 32'h0000_0000;
  // Status fields
  localparam int          ST_STRAP_BIT  = 0;
  localparam int          ST_BUSY_BIT   = 1;
  localparam int          ST_WAITED_BIT = 2;
  // Boot segment F000:0 to FFFF:F is address[19:16] == f
  localparam logic [3:0]  BOOT_SEG      = 4'hf;
  // Strobe minimum width
  localparam int          CLK_NS        = 10;
  localparam int          STROBE_NS     = 30;
  localparam int          STROBE_CYCLES = (STROBE_NS + CLK_NS - 1) / CLK_NS;

  typedef struct packed {
    logic              valid;
    logic              is_io;
    logic              is_write;
    logic              is_word;
    logic              internal;
    logic [ADDR_W-1:0] addr;
  } bus_req_type;

  typedef struct packed {
    logic io_rd;
    logic io_wr;
    logic mem_rd;
    logic mem_wr;
  } strobe_type;

  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_STROBE = 2'b01,
    ST_GAP    = 2'b10
  } state_type;
endpackage : strobe_decode_pkg

// ### hdl/system_bus_strobe_decode.sv
// The address map and the APB interface to the registers are this design's own decisions.
`timescale 1ns/100ps
// How it works
// - The first ROM enable fires on memory reads in the boot segment unless it is shadowed.
// - Two software windows may fire either ROM enable for further address ranges.
// - An I/O read raises the I/O read strobe so the external device drives the data bus.
// - A control bit suppresses the I/O read strobe for cycles to internal peripherals.
// - An I/O write raises the I/O write strobe while write data is on the bus.
// - A control bit suppresses the I/O write strobe for cycles to internal peripherals.
// - The memory read strobe stays low on reads of system RAM.
// - A control bit lets the memory read strobe act as output enable of either ROM.
// - A memory write to expansion memory raises the memory write strobe.
// - The memory write strobe stays low on writes to system RAM or ROM.
// - A low channel ready, combined with internal ready, stretches the cycle with waits.
// - The width strap, caught after reset, makes word ROM reads two byte cycles when high.
module system_bus_strobe_decode
  import strobe_decode_pkg::*;
#(
  parameter int STROBE_MIN = STROBE_CYCLES
) (
  input  wire logic                  clk,
  input  wire logic                  reset_n,
  input  wire logic [APB_ADDR_W-1:0] paddr,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [31:0]           pwdata,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  input  wire bus_req_type           bus_req,
  output logic                       cycle_done,
  input  wire logic                  channel_ready_in,
  input  wire logic                  internal_ready_in,
  input  wire logic                  rom_width_strap,
  output logic                       io_read_strobe,
  output logic                       io_write_strobe,
  output logic                       mem_read_strobe,
  output logic                       mem_write_strobe,
  output logic      [1:0]            rom_chip_enable,
  output logic                       rom_byte_high
);

  // Counter is eight bits wide
  if (STROBE_MIN < 1 || STROBE_MIN > 255) begin : gen_bad_strobe_min
    $error("STROBE_MIN out of range");
  end

  logic [31:0]       ctrl_reg;
  logic [31:0]       win_reg [2];
  logic [31:0]       prdata_reg;
  logic              pslverr_reg;
  logic              strap_8bit_reg;
  logic              strap_taken_reg;
  logic              waited_reg;
  state_type         state_reg;
  strobe_type        strobe_reg;
  strobe_type        strobe_next;
  logic [1:0]        ce_reg;
  logic [1:0]        ce_next;
  logic [7:0]        cnt_reg;
  logic              split_reg;
  logic              byte_high_reg;
  logic              done_reg;
  logic [PAGE_W-1:0] page;
  logic [1:0]        win_hit;
  logic              boot_seg;
  logic              boot_hit;
  logic              rom_hit;
  logic              ram_hit;
  logic              mem_rd_req;
  logic              mem_wr_req;
  logic              io_rd_req;
  logic              io_wr_req;
  logic              split_next;
  logic              accept;
  logic              ready_all;
  logic              addr_ok;
  logic [31:0]       read_mux;

  // Address decode
  assign page     = bus_req.addr[ADDR_W-1 -: PAGE_W];
  assign boot_seg = bus_req.addr[ADDR_W-1 -: 4] == BOOT_SEG;
  assign boot_hit = boot_seg && !ctrl_reg[SHADOW_BIT];

  generate
    for (genvar g = 0; g < 2; g++) begin : gen_win
      logic [PAGE_W-1:0] base;
      logic [PAGE_W-1:0] mask;
      assign base = win_reg[g][WIN_BASE_LSB +: PAGE_W];
      assign mask = win_reg[g][WIN_MASK_LSB +: PAGE_W];
      // Mask bit set means the page bit is compared
      assign win_hit[g] = win_reg[g][WIN_EN_BIT] && (((page ^ base) & mask) == '0);
    end
  endgenerate

  assign rom_hit = boot_hit || (|win_hit);
  // Shadowed boot segment reads and writes go to RAM
  assign ram_hit = !rom_hit
                   && (page < ctrl_reg[RAM_LIMIT_LSB +: PAGE_W] || boot_seg);

  assign mem_rd_req = !bus_req.is_io && !bus_req.is_write;
  assign mem_wr_req = !bus_req.is_io && bus_req.is_write;
  assign io_rd_req  = bus_req.is_io && !bus_req.is_write;
  assign io_wr_req  = bus_req.is_io && bus_req.is_write;
  assign accept     = state_reg == ST_IDLE && bus_req.valid;
  assign ready_all  = channel_ready_in && internal_ready_in;

  always_comb begin
    strobe_next        = '0;
    ce_next            = '0;
    strobe_next.io_rd  = io_rd_req && !(bus_req.internal && ctrl_reg[INH_RD_BIT]);
    strobe_next.io_wr  = io_wr_req && !(bus_req.internal && ctrl_reg[INH_WR_BIT]);
    // RAM reads are served by the memory controller
    strobe_next.mem_rd = mem_rd_req && !ram_hit
                         && (!rom_hit || ctrl_reg[ROM_OE_BIT]);
    strobe_next.mem_wr = mem_wr_req && !ram_hit && !rom_hit;
    if (mem_rd_req && boot_hit) begin
      ce_next[0] = 1'b1;
    end else if (mem_rd_req && win_hit[0]) begin
      ce_next[win_reg[0][WIN_SEL_BIT]] = 1'b1;
    end else if (mem_rd_req && win_hit[1]) begin
      ce_next[win_reg[1][WIN_SEL_BIT]] = 1'b1;
    end
  end

  // Eight-bit ROM takes a word read as two byte cycles
  assign split_next = mem_rd_req && rom_hit && bus_req.is_word && strap_8bit_reg;

  // Strap is caught on the first edge after reset release
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      strap_taken_reg <= 1'b0;
      strap_8bit_reg  <= 1'b0;
    end else if (!strap_taken_reg) begin
      strap_taken_reg <= 1'b1;
      strap_8bit_reg  <= rom_width_strap;
    end
  end

  // Cycle sequencer
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg     <= ST_IDLE;
      strobe_reg    <= '0;
      ce_reg        <= '0;
      cnt_reg       <= '0;
      split_reg     <= 1'b0;
      byte_high_reg <= 1'b0;
      done_reg      <= 1'b0;
      waited_reg    <= 1'b0;
    end else begin
      done_reg <= 1'b0;
      case (state_reg)
        ST_IDLE: begin
          if (accept) begin
            waited_reg    <= 1'b0;
            byte_high_reg <= 1'b0;
            if ((|strobe_next) || (|ce_next)) begin
              strobe_reg <= strobe_next;
              ce_reg     <= ce_next;
              split_reg  <= split_next;
              cnt_reg    <= 8'(STROBE_MIN - 1);
              state_reg  <= ST_STROBE;
            end else begin
              // Internal, RAM or ROM write cycle, nothing to drive
              done_reg  <= 1'b1;
              state_reg <= ST_GAP;
            end
          end
        end
        ST_STROBE: begin
          if (cnt_reg != '0) begin
            cnt_reg <= cnt_reg - 8'd1;
          end else if (!ready_all) begin
            waited_reg <= 1'b1;
          end else if (split_reg) begin
            split_reg     <= 1'b0;
            byte_high_reg <= 1'b1;
            cnt_reg       <= 8'(STROBE_MIN - 1);
          end else begin
            strobe_reg    <= '0;
            ce_reg        <= '0;
            byte_high_reg <= 1'b0;
            done_reg      <= 1'b1;
            state_reg     <= ST_GAP;
          end
        end
        ST_GAP: begin
          // Lets the requester drop valid before a new accept
          state_reg <= ST_IDLE;
        end
        default: begin
          state_reg  <= ST_IDLE;
          strobe_reg <= '0;
          ce_reg     <= '0;
        end
      endcase
    end
  end

  assign io_read_strobe   = strobe_reg.io_rd;
  assign io_write_strobe  = strobe_reg.io_wr;
  assign mem_read_strobe  = strobe_reg.mem_rd;
  assign mem_write_strobe = strobe_reg.mem_wr;
  assign rom_chip_enable  = ce_reg;
  assign rom_byte_high    = byte_high_reg;
  assign cycle_done       = done_reg;

  // APB slave, zero wait states
  assign addr_ok = paddr == CTRL_OFFSET || paddr == WIN0_OFFSET
                   || paddr == WIN1_OFFSET || paddr == STATUS_OFFSET;

  always_comb begin
    read_mux = '0;
    case (paddr)
      CTRL_OFFSET:   read_mux = ctrl_reg;
      WIN0_OFFSET:   read_mux = win_reg[0];
      WIN1_OFFSET:   read_mux = win_reg[1];
      STATUS_OFFSET: begin
        read_mux[ST_STRAP_BIT]  = strap_8bit_reg;
        read_mux[ST_BUSY_BIT]   = state_reg != ST_IDLE;
        read_mux[ST_WAITED_BIT] = waited_reg;
      end
      default:       read_mux = '0;
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      prdata_reg  <= '0;
      pslverr_reg <= 1'b0;
    end else if (psel && !penable) begin
      prdata_reg  <= pwrite ? 32'h0000_0000 : read_mux;
      pslverr_reg <= !addr_ok;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_reg   <= CTRL_RESET;
      win_reg[0] <= WIN_RESET;
      win_reg[1] <= WIN_RESET;
    end else if (psel && penable && pwrite) begin
      case (paddr)
        CTRL_OFFSET: ctrl_reg   <= pwdata;
        WIN0_OFFSET: win_reg[0] <= pwdata;
        WIN1_OFFSET: win_reg[1] <= pwdata;
        default:     ;
      endcase
    end
  end

  assign prdata  = prdata_reg;
  assign pready  = 1'b1;
  assign pslverr = pslverr_reg && psel && penable;

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  sequence s_mem_rd;
    accept && mem_rd_req;
  endsequence

  sequence s_no_io_rd;
    !io_read_strobe ##1 !io_read_strobe;
  endsequence

  AST_BOOT_CE: assert property (
    s_mem_rd and boot_hit |=> rom_chip_enable == 2'b01)
    else $error("boot ROM enable missing");
  AST_WIN_CE: assert property (
    s_mem_rd and (!boot_hit && |win_hit) |=> rom_chip_enable != 2'b00 && !io_read_strobe)
    else $error("window ROM enable missing");
  AST_IO_RD: assert property (
    accept && io_rd_req && !bus_req.internal |=> io_read_strobe [*3])
    else $error("I/O read strobe missing");
  AST_IO_RD_INH: assert property (
    accept && io_rd_req && bus_req.internal && ctrl_reg[INH_RD_BIT] |=> s_no_io_rd)
    else $error("I/O read strobe not inhibited");
  AST_IO_WR: assert property (
    accept && io_wr_req && !bus_req.internal |=> io_write_strobe && !mem_write_strobe)
    else $error("I/O write strobe missing");
  AST_IO_WR_INH: assert property (
    accept && io_wr_req && bus_req.internal && ctrl_reg[INH_WR_BIT]
    |=> !io_write_strobe && cycle_done)
    else $error("I/O write strobe not inhibited");
  AST_RAM_RD: assert property (
    s_mem_rd and ram_hit |=> !mem_read_strobe ##1 !mem_read_strobe)
    else $error("memory read strobe on RAM read");
  AST_ROM_OE: assert property (
    s_mem_rd and (rom_hit && ctrl_reg[ROM_OE_BIT]) |=> mem_read_strobe && rom_chip_enable != 0)
    else $error("memory read strobe not acting as ROM enable");
  AST_MEM_WR: assert property (
    accept && mem_wr_req && !ram_hit && !rom_hit |=> mem_write_strobe)
    else $error("memory write strobe missing");
  AST_MEM_WR_RAM: assert property (
    accept && mem_wr_req && (ram_hit || rom_hit) |=> !mem_write_strobe)
    else $error("memory write strobe on RAM or ROM");
  AST_WAIT: assert property (
    state_reg == ST_STROBE && cnt_reg == 0 && !ready_all
    |=> state_reg == ST_STROBE && $stable(strobe_reg) && !cycle_done)
    else $error("cycle ended while not ready");
  AST_SPLIT: assert property (
    s_mem_rd and split_next |=> !rom_byte_high ##[1:1000] rom_byte_high)
    else $error("second ROM byte cycle missing");
  AST_ONE_STROBE: assert property (
    $onehot0({io_read_strobe, io_write_strobe, mem_read_strobe, mem_write_strobe}))
    else $error("more than one strobe active");
  AST_GAP_QUIET: assert property (
    state_reg != ST_STROBE |-> strobe_reg == '0 && rom_chip_enable == 2'b00)
    else $error("strobe active between cycles");

endmodule : system_bus_strobe_decode

// ### bench/bus_partner_model.sv
`timescale 1ns/100ps
module bus_partner_model (
  input  wire logic       clk,
  input  wire logic       reset_n,
  input  wire logic [3:0] strobes,
  input  wire logic [1:0] chip_enables,
  input  wire logic [7:0] slow_cycles,
  output logic            channel_ready_in
);
  logic [7:0] busy_cnt_reg;
  logic       active;

  assign active = (strobes != 4'h0) || (chip_enables != 2'h0);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n)
      busy_cnt_reg <= 8'h00;
    else if (active)
      busy_cnt_reg <= busy_cnt_reg + 8'h01;
    else
      busy_cnt_reg <= 8'h00;
  end

  // Pulled-up line; a slow device holds it low from strobe start
  assign channel_ready_in = !active || (busy_cnt_reg >= slow_cycles);
endmodule : bus_partner_model

// ### bench/system_bus_strobe_decode_tb_top.sv
`timescale 1ns/100ps
module system_bus_strobe_decode_tb_top;
  import strobe_decode_pkg::*;
  localparam logic [4:0] IO_RD = 5'h18;
  localparam logic [4:0] IO_WR = 5'h1c;
  localparam logic [4:0] M_RD  = 5'h10;
  localparam logic [4:0] M_WR  = 5'h14;
  localparam logic [4:0] INT   = 5'h01;
  localparam logic [4:0] WORD  = 5'h02;
  localparam logic [14:0] NONE = 15'h0000;
  logic        clk;
  logic        reset_n;
  logic [7:0]  paddr;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  bus_req_type bus_req;
  logic        cycle_done;
  logic        channel_ready_in;
  logic        internal_ready_in;
  logic        rom_width_strap;
  logic [3:0]  stb;
  logic [1:0]  rom_chip_enable;
  logic        rom_byte_high;
  logic [7:0]  slow_cycles;
  logic [31:0] rd;
  logic        er;
  int          err_total;
  int          n_checks;

  system_bus_strobe_decode #(.STROBE_MIN(3)) u_system_bus_strobe_decode (
    .clk(clk), .reset_n(reset_n), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .bus_req(bus_req), .cycle_done(cycle_done),
    .channel_ready_in(channel_ready_in), .internal_ready_in(internal_ready_in),
    .rom_width_strap(rom_width_strap), .io_read_strobe(stb[3]),
    .io_write_strobe(stb[2]), .mem_read_strobe(stb[1]), .mem_write_strobe(stb[0]),
    .rom_chip_enable(rom_chip_enable), .rom_byte_high(rom_byte_high));

  bus_partner_model u_bus_partner_model (
    .clk(clk), .reset_n(reset_n), .strobes(stb), .chip_enables(rom_chip_enable),
    .slow_cycles(slow_cycles), .channel_ready_in(channel_ready_in));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : stop_test

  initial begin
    #50000;
    err_total++;
    stop_test();
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic do_reset(input logic strap);
    reset_n <= 1'b0;
    rom_width_strap <= strap;
    repeat (2) @(posedge clk);
    #1 check({25'h0, stb, rom_chip_enable, cycle_done}, 32'h0);
    @(posedge clk);
    reset_n <= 1'b1;
    // Strap is caught at the first edge, so wait two
    repeat (2) @(posedge clk);
  endtask : do_reset

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // Only the watchdog ends a wait
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Expectation packs cycles with any strobe or enable, byte-high, enables, strobes
  task automatic cyc(input logic [4:0] f, input logic [19:0] a, input logic [14:0] e);
    logic [14:0] got;
    int          many;
    got = 15'h0;
    many = 0;
    @(posedge clk);
    bus_req <= {f, a};
    while (cycle_done !== 1'b1) begin
      @(posedge clk);
      #1;
      got[6:0] = got[6:0] | {rom_byte_high, rom_chip_enable, stb};
      if (stb != 4'h0 || rom_chip_enable != 2'h0)
        got[14:7] = got[14:7] + 8'h01;
      if ($countones(stb) > 1)
        many++;
    end
    check({26'h0, stb, rom_chip_enable}, 32'h0);
    check(32'(many), 32'h0);
    check({17'h0, got}, {17'h0, e});
    // Done cycle is a refused gap, so dropping valid here is in time
    @(posedge clk);
    bus_req.valid <= 1'b0;
  endtask : cyc

  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    bus_req = '0;
    internal_ready_in = 1'b1;
    slow_cycles = 8'h00;
    err_total = 0;
    n_checks = 0;
    do_reset(1'b0);
    apb(1'b0, CTRL_OFFSET, 32'h0);
    check(rd, CTRL_RESET);
    apb(1'b0, 8'h10, 32'h0);
    check({rd[30:0], er}, 32'h1);
    apb(1'b0, STATUS_OFFSET, 32'h0);
    check({31'h0, rd[ST_STRAP_BIT]}, 32'h0);
    cyc(IO_RD, 20'h003f0, {8'h03, 1'b0, 2'h0, 4'h8});
    cyc(IO_WR, 20'h003f8, {8'h03, 1'b0, 2'h0, 4'h4});
    cyc(IO_RD | INT, 20'h00020, {8'h03, 1'b0, 2'h0, 4'h8});
    apb(1'b1, CTRL_OFFSET, CTRL_RESET | 32'h6);
    cyc(IO_RD | INT, 20'h00020, NONE);
    cyc(IO_WR | INT, 20'h00021, NONE);
    cyc(IO_WR, 20'h00300, {8'h03, 1'b0, 2'h0, 4'h4});
    cyc(M_RD, 20'h12340, NONE);
    cyc(M_RD, 20'hb0000, {8'h03, 1'b0, 2'h0, 4'h2});
    cyc(M_RD, 20'hf1230, {8'h03, 1'b0, 2'h1, 4'h0});
    cyc(M_WR, 20'hb0010, {8'h03, 1'b0, 2'h0, 4'h1});
    cyc(M_WR, 20'h01000, NONE);
    cyc(M_WR, 20'hf0000, NONE);
    apb(1'b1, CTRL_OFFSET, CTRL_RESET | 32'h8);
    cyc(M_RD, 20'hf1230, {8'h03, 1'b0, 2'h1, 4'h2});
    apb(1'b1, WIN0_OFFSET, 32'h000ffc83);
    apb(1'b1, WIN1_OFFSET, 32'h000ffd01);
    apb(1'b0, WIN0_OFFSET, 32'h0);
    check(rd, 32'h000ffc83);
    cyc(M_RD, 20'hc8000, {8'h03, 1'b0, 2'h2, 4'h2});
    cyc(M_RD, 20'hd0000, {8'h03, 1'b0, 2'h1, 4'h2});
    apb(1'b1, CTRL_OFFSET, CTRL_RESET | 32'h9);
    cyc(M_RD, 20'hf1230, NONE);
    slow_cycles <= 8'h05;
    cyc(IO_RD, 20'h003f0, {8'h06, 1'b0, 2'h0, 4'h8});
    slow_cycles <= 8'h00;
    apb(1'b0, STATUS_OFFSET, 32'h0);
    check(rd, 32'h4);
    do_reset(1'b1);
    apb(1'b0, STATUS_OFFSET, 32'h0);
    check({31'h0, rd[ST_STRAP_BIT]}, 32'h1);
    // Eight-bit ROM on the low lane needs two byte cycles per word
    cyc(M_RD | WORD, 20'hf0000, {8'h06, 1'b1, 2'h1, 4'h0});
    stop_test();
  end
endmodule : system_bus_strobe_decode_tb_top
